// File: rtl/sbm_dev.sv
// Device end: mode register, command decode, burst address and read data timing
// Notes on behaviour
// [R1] Burst order bit picks sequential or interleaved
// [R2] Sequential bursts wrap inside aligned block
// [R3] Interleaved offset is start XOR index
// [R4] Low column bits start, upper bits block
// [R5] Full page: 512 columns, sequential, wraps
// [R6] Length one: single column, order ignored
// [R7] Read latency two or three cycles
// [R8] Drive from n+m-1, data valid n+m
// [R9] Controller picks latency two only slowly; sbm_ctl loads whatever latency code the user gives
// [R10] Normal mode only with op bits zero
// [R11] Controller never programs reserved codes; sbm_ctl passes whatever code the user gives
// [R12] Write single bit makes writes one location
// [R13] Inhibit registers nothing, bursts continue
// [R14] NOP does nothing, bursts continue
// [R15] Mode load stores address bits 0-11
// [R16] Mode load only idle, then wait; sbm_ctl waits 2 cycles but does not check for idle
// [R17] Active opens row per bank
// [R18] Precharge before activating another row; neither sbm_ctl nor sbm_dev checks this, the user must
// [R19] Read starts burst, auto close option
// [R20] Byte mask gates outputs two clocks later
// [R21] Mode register field layout
// [R22] Active-low command encodings
// [R23] Burst length code decode
// [R24] Latency code decode
`timescale 1ns/100ps
`include "sbm_map.svh"
module sbm_dev #(
    parameter int COLS = 512
) (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_srst,
    // Pins
    sbm_if.dev               pins,
    // Status
    output logic [11:0]      o_mode,
    output logic [3:0]       o_row_open,
    output logic             o_normal,
    output logic             o_wr_single,
    output logic [8:0]       o_col,
    output logic             o_col_valid
);
    import sbm_pkg::*;

    // ****************************************
    // Command decode
    // ****************************************
    logic [3:0]  pin_cmd;
    logic        is_load;
    logic        is_act;
    logic        is_read;
    logic        is_write;
    assign pin_cmd  = {pins.sel_n, pins.row_strobe_n, pins.col_strobe_n, pins.wr_en_n};
    assign is_load  = !pins.sel_n && pin_cmd == 4'(SBM_CMD_LOAD);   // [R22] [R13] [R14]
    assign is_act   = !pins.sel_n && pin_cmd == 4'(SBM_CMD_ACTIVE);
    assign is_read  = !pins.sel_n && pin_cmd == 4'(SBM_CMD_READ);
    assign is_write = !pins.sel_n && pin_cmd == 4'(SBM_CMD_WRITE);

    // ****************************************
    // Mode register and fields
    // ****************************************
    logic [11:0] operating_configuration_ff;
    logic [2:0]  burst_len_field;
    logic        burst_order_bit;
    logic [2:0]  read_latency_field;
    logic        op_mode_bit_low;
    logic        op_mode_bit_high;
    logic        write_single_bit;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            operating_configuration_ff <= `SBM_MODE_RESET;
        end else if (is_load) begin
            operating_configuration_ff <= pins.addr;  // [R15]
        end
    end

    assign burst_len_field    = operating_configuration_ff[`SBM_BL_MSB:`SBM_BL_LSB];  // [R21]
    assign burst_order_bit    = operating_configuration_ff[`SBM_ORDER_BIT];
    assign read_latency_field = operating_configuration_ff[`SBM_LAT_MSB:`SBM_LAT_LSB];
    assign op_mode_bit_low    = operating_configuration_ff[`SBM_OPM_LSB];
    assign op_mode_bit_high   = operating_configuration_ff[`SBM_OPM_MSB];
    assign write_single_bit   = operating_configuration_ff[`SBM_WSB_BIT];
    assign o_mode      = operating_configuration_ff;
    assign o_normal    = {op_mode_bit_high, op_mode_bit_low} == `SBM_OPM_NORMAL;  // [R10]
    assign o_wr_single = write_single_bit;

    // Burst length code to span mask and count
    logic [8:0] blk_mask;
    logic [9:0] blen;
    logic       len_ok;
    always_comb begin
        len_ok = 1'b1;
        case (burst_len_field)  // [R23]
            `SBM_BL_1: begin
                blk_mask = 9'h000;
                blen     = 10'h001;
            end
            `SBM_BL_2: begin
                blk_mask = 9'h001;
                blen     = 10'h002;
            end
            `SBM_BL_4: begin
                blk_mask = 9'h003;
                blen     = 10'h004;
            end
            `SBM_BL_8: begin
                blk_mask = 9'h007;
                blen     = 10'h008;
            end
            `SBM_BL_PAGE: begin
                blk_mask = 9'(COLS - 1);      // [R5]
                blen     = `SBM_PAGE_LEN;
            end
            default: begin
                blk_mask = 9'h000;
                blen     = 10'h001;
                len_ok   = 1'b0;
            end
        endcase
    end

    // Latency code to cycles, reserved codes give no read
    logic [1:0] lat;
    always_comb begin
        case (read_latency_field)  // [R24] [R7]
            `SBM_LAT_2: lat = 2'h2;
            `SBM_LAT_3: lat = 2'h3;
            default:    lat = 2'h0;
        endcase
    end

    // ****************************************
    // Open rows per bank
    // ****************************************
    sbm_state_t  state_ff;
    logic [8:0]  start_ff;
    logic [8:0]  idx_ff;
    logic [9:0]  cnt_ff;
    logic        ilv_ff;
    logic        close_ff;
    logic [1:0]  bank_ff;
    logic [8:0]  mask_ff;
    logic        rd_ff;
    logic        go;
    logic [8:0]  cur_col;
    logic [11:0] row_ff [4];
    logic [3:0]  open_ff;
    // Close and open handled apart so an open of another bank keeps the close
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            open_ff <= 4'h0;
        end else begin
            if (state_ff == SBM_ST_BURST && cnt_ff == 10'h001 && close_ff) begin
                open_ff[bank_ff] <= 1'b0;  // [R19]
            end
            if (is_act && o_normal) begin
                open_ff[pins.bank_select] <= 1'b1;  // [R17]
                row_ff[pins.bank_select]  <= pins.addr;
            end
        end
    end
    assign o_row_open = open_ff;

    // ****************************************
    // Burst address generation
    // ****************************************
    assign go = (is_read || is_write) && o_normal && len_ok && open_ff[pins.bank_select]
                && (is_write || lat != 2'h0);

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            state_ff <= SBM_ST_IDLE;
            cnt_ff   <= 10'h000;
            idx_ff   <= 9'h000;
            start_ff <= 9'h000;
            ilv_ff   <= 1'b0;
            close_ff <= 1'b0;
            bank_ff  <= 2'h0;
            mask_ff  <= 9'h000;
            rd_ff    <= 1'b0;
        end else if (go) begin
            state_ff <= SBM_ST_BURST;  // [R19]
            start_ff <= pins.addr[8:0];
            idx_ff   <= 9'h000;
            cnt_ff   <= (is_write && write_single_bit) ? 10'h001 : blen;  // [R12]
            mask_ff  <= (is_write && write_single_bit) ? 9'h000 : blk_mask;
            ilv_ff   <= burst_order_bit && burst_len_field != `SBM_BL_1
                        && burst_len_field != `SBM_BL_PAGE;  // [R1] [R5] [R6]
            close_ff <= pins.addr[`SBM_AUTO_BIT] && burst_len_field != `SBM_BL_PAGE;
            bank_ff  <= pins.bank_select;
            rd_ff    <= is_read;
        end else if (state_ff == SBM_ST_BURST) begin
            idx_ff <= idx_ff + 9'h001;  // [R13] [R14]
            cnt_ff <= cnt_ff - 10'h001;
            if (cnt_ff == 10'h001) begin
                state_ff <= SBM_ST_IDLE;
            end
        end
    end

    // Block from upper bits, offset from low bits under the mask
    always_comb begin
        if (ilv_ff) begin
            cur_col = (start_ff & ~mask_ff) | ((start_ff ^ idx_ff) & mask_ff);  // [R3] [R4]
        end else begin
            cur_col = (start_ff & ~mask_ff) | ((start_ff + idx_ff) & mask_ff);  // [R2] [R5]
        end
    end
    assign o_col       = cur_col;
    assign o_col_valid = (state_ff == SBM_ST_BURST);

    // ****************************************
    // Read data timing and byte masks
    // ****************************************
    // Column enters a pipe at n+1; it reaches the pins at n+m-1 (drive start)
    logic [8:0]  colp_ff;
    logic        vp_ff;
    logic [1:0] bm1_ff;
    logic [1:0] bm2_ff;
    logic [15:0] dq_ff;
    logic        drv_ff;
    logic        rdv;

    assign rdv = o_col_valid && rd_ff;
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            vp_ff  <= 1'b0;
            bm1_ff <= 2'h3;
            bm2_ff <= 2'h3;
            dq_ff  <= 16'h0000;
            drv_ff <= 1'b0;
        end else begin
            vp_ff      <= rdv;
            colp_ff    <= cur_col;
            bm1_ff     <= pins.byte_mask;  // [R20]
            bm2_ff     <= bm1_ff;
            drv_ff     <= (lat == 2'h2) ? rdv : vp_ff;  // [R8]
            dq_ff      <= {7'h00, (lat == 2'h2) ? cur_col : colp_ff};
        end
    end

    // Data word carries its column so bursts are observable
    assign pins.dq_from_dev = dq_ff;
    generate
        for (genvar b = 0; b < 2; b++) begin : g_lane
            assign pins.dq_oe_dev[b*8 +: 8] = {8{drv_ff && !bm2_ff[b]}};  // [R20]
        end
    endgenerate
endmodule : sbm_dev

// File: rtl/sbm_map.svh
// Constants for the burst and command logic: mode fields, codes and timing
`ifndef SBM_MAP_SVH
`define SBM_MAP_SVH
`define SBM_BL_LSB      0
`define SBM_BL_MSB      2
`define SBM_ORDER_BIT   3
`define SBM_LAT_LSB     4
`define SBM_LAT_MSB     6
`define SBM_OPM_LSB     7
`define SBM_OPM_MSB     8
`define SBM_WSB_BIT     9
`define SBM_MODE_RESET  12'h000
`define SBM_BL_1        3'h0
`define SBM_BL_2        3'h1
`define SBM_BL_4        3'h2
`define SBM_BL_8        3'h3
`define SBM_BL_PAGE     3'h7
`define SBM_LAT_2       3'h2
`define SBM_LAT_3       3'h3
`define SBM_OPM_NORMAL  2'h0
`define SBM_AUTO_BIT    10
`define SBM_PAGE_LEN    10'h200
`define SBM_MRD_CYC     2
`endif

// File: rtl/sbm_pkg.sv
// Types shared by the controller and device ends
package sbm_pkg;
    typedef enum logic [3:0] {
        SBM_CMD_INHIBIT = 4'h8,
        SBM_CMD_NOP     = 4'h7,
        SBM_CMD_ACTIVE  = 4'h3,
        SBM_CMD_READ    = 4'h5,
        SBM_CMD_WRITE   = 4'h4,
        SBM_CMD_LOAD    = 4'h0
    } sbm_cmd_t;
    typedef enum logic [1:0] {
        SBM_ST_IDLE  = 2'h0,
        SBM_ST_BURST = 2'h1
    } sbm_state_t;
endpackage : sbm_pkg

// File: rtl/sbm_if.sv
// Command, address, mask and data pins between controller and device
`timescale 1ns/100ps
interface sbm_if;
    logic        sel_n;
    logic        row_strobe_n;
    logic        col_strobe_n;
    logic        wr_en_n;
    logic [1:0]  bank_select;
    logic [11:0] addr;
    logic [1:0]  byte_mask;
    logic [15:0] dq_from_dev;
    logic [15:0] dq_oe_dev;
    logic [15:0] dq_from_ctl;
    logic        dq_oe_ctl;
    modport ctl (output sel_n, row_strobe_n, col_strobe_n, wr_en_n, bank_select, addr,
                 byte_mask, dq_from_ctl, dq_oe_ctl, input dq_from_dev, dq_oe_dev);
    modport dev (input sel_n, row_strobe_n, col_strobe_n, wr_en_n, bank_select, addr,
                 byte_mask, dq_from_ctl, dq_oe_ctl, output dq_from_dev, dq_oe_dev);
endinterface : sbm_if

// File: rtl/sbm_ctl.sv
// Controller end: turns user requests into commands on the pins
`timescale 1ns/100ps
`include "sbm_map.svh"
module sbm_ctl (
    // Clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_srst,
    // User request
    input  wire logic              i_req,
    input  wire sbm_pkg::sbm_cmd_t i_cmd,
    input  wire logic [1:0]        i_bank,
    input  wire logic [11:0]       i_addr,
    input  wire logic [1:0]        i_mask,
    output logic                   o_ready,
    // Pins
    sbm_if.ctl                     pins
);
    import sbm_pkg::*;

    logic [1:0]  wait_ff;
    logic [3:0]  cmd_ff;
    logic [1:0]  bank_ff;
    logic [11:0] addr_ff;
    logic [1:0]  mask_ff;

    // Hold off after a mode load
    assign o_ready = (wait_ff == 2'h0);

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            wait_ff <= 2'h0;
        end else if (i_req && o_ready && i_cmd == SBM_CMD_LOAD) begin
            wait_ff <= 2'(`SBM_MRD_CYC);  // [R16]
        end else if (wait_ff != 2'h0) begin
            wait_ff <= wait_ff - 2'h1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            cmd_ff  <= 4'h8;
            bank_ff <= 2'h0;
            addr_ff <= 12'h000;
            mask_ff <= 2'h0;
        end else begin
            cmd_ff  <= (i_req && o_ready) ? 4'(i_cmd) : 4'(SBM_CMD_NOP);
            bank_ff <= i_bank;
            addr_ff <= i_addr;
            mask_ff <= i_mask;
        end
    end

    // User must keep mode codes legal and precharge before a new row [R11] [R18]
    assign pins.sel_n        = cmd_ff[3];  // [R22]
    assign pins.row_strobe_n = cmd_ff[2];
    assign pins.col_strobe_n = cmd_ff[1];
    assign pins.wr_en_n      = cmd_ff[0];
    assign pins.bank_select  = bank_ff;
    assign pins.addr         = addr_ff;
    assign pins.byte_mask    = mask_ff;
    assign pins.dq_from_ctl  = 16'h0000;
    assign pins.dq_oe_ctl    = 1'b0;
endmodule : sbm_ctl

// File: dv/sbm_properties.sv
// Pin-level checker for the controller and device ends
`timescale 1ns/100ps
module sbm_properties (
    // Clock and reset
    input wire logic        i_mclk,
    input wire logic        i_srst,
    // Pins
    input wire logic        sel_n,
    input wire logic        row_strobe_n,
    input wire logic        col_strobe_n,
    input wire logic        wr_en_n,
    input wire logic [11:0] addr,
    input wire logic [1:0]  byte_mask,
    input wire logic [15:0] dq_oe_dev
);
    logic [11:0] mode_ff;
    logic [2:0]  code;
    logic        load, rd, nop, mok, ok;
    assign code = {row_strobe_n, col_strobe_n, wr_en_n};
    assign load = !sel_n && code == 3'h0;
    assign rd   = !sel_n && code == 3'h5;
    assign nop  = sel_n || code == 3'h7;
    assign mok  = mode_ff[8:7] == 2'h0 && mode_ff[2:0] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    assign ok   = mok && byte_mask == 2'h0;
    // Shadow of the mode register
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            mode_ff <= 12'h000;
        end else if (load) begin
            mode_ff <= addr;
        end
    end
    // ****
    // Properties
    // ****
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    sequence rd2_s; rd && ok && mode_ff[6:4] == 3'h2; endsequence
    sequence rd3_s; rd && ok && mode_ff[6:4] == 3'h3; endsequence
    sequence calm_s; !rd && byte_mask == 2'h0; endsequence
    lat_two_a: assert property (rd2_s |-> ##2 dq_oe_dev == 16'hffff)
        else $error("first beat late at latency two");
    lat_three_a: assert property (rd3_s ##1 calm_s ##1 calm_s |-> ##1 dq_oe_dev == 16'hffff)
        else $error("first beat late at latency three");
    mask_gate_a: assert property (|dq_oe_dev |-> dq_oe_dev ==
        {{8{!$past(byte_mask[1], 2)}}, {8{!$past(byte_mask[0], 2)}}})
        else $error("lane enable does not follow mask");
    mode_wait_a: assert property (load |=> nop [*2])
        else $error("command too soon after mode load");
    cmd_legal_a: assert property (!sel_n |-> code inside {3'h3, 3'h5, 3'h7, 3'h0, 3'h4})
        else $error("illegal command encoding");
    bad_mode_a: assert property (!rd ##1 !rd ##1 rd
        && !(mok && mode_ff[6:4] inside {3'h2, 3'h3}) && dq_oe_dev == 16'h0
        |=> (dq_oe_dev == 16'h0) [*4])
        else $error("refused read drove data");
    single_beat_a: assert property ((rd2_s and mode_ff[2:0] == 3'h0) ##1 calm_s ##1 calm_s
        |-> ##1 dq_oe_dev == 16'h0)
        else $error("length one burst too long");
    burst_two_a: assert property ((rd2_s and mode_ff[2:0] == 3'h1) ##1 calm_s [*3]
        |-> dq_oe_dev == 16'hffff ##1 dq_oe_dev == 16'h0)
        else $error("length two burst wrong");
endmodule : sbm_properties

// File: dv/sbm_tb_top.sv
// Testbench: controller end drives device end across the pin interface
`timescale 1ns/100ps
module sbm_tb_top;
    import sbm_pkg::*;
    logic        i_mclk = 1'b0;
    logic        i_srst = 1'b1;
    logic        i_req  = 1'b0;
    sbm_cmd_t    i_cmd  = SBM_CMD_NOP;
    logic [1:0]  i_bank = 2'h0;
    logic [11:0] i_addr = 12'h000;
    logic [1:0]  i_mask = 2'h0;
    logic        o_ready, o_normal, o_wr_single;
    logic [11:0] o_mode;
    logic [3:0]  o_row_open, opened;
    logic [24:0] exp_q[$];
    logic [8:0]  o_col;
    logic        o_col_valid;
    logic [8:0]  col_q[$];
    int          num_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;
    sbm_if ifc ();
    sbm_ctl i_sbm_ctl (.i_mclk(i_mclk), .i_srst(i_srst), .i_req(i_req), .i_cmd(i_cmd),
        .i_bank(i_bank), .i_addr(i_addr), .i_mask(i_mask), .o_ready(o_ready), .pins(ifc.ctl));
    sbm_dev i_sbm_dev (.i_mclk(i_mclk), .i_srst(i_srst), .pins(ifc.dev), .o_mode(o_mode),
        .o_row_open(o_row_open), .o_normal(o_normal), .o_wr_single(o_wr_single),
        .o_col(o_col), .o_col_valid(o_col_valid));
    sbm_properties i_sbm_properties (.i_mclk(i_mclk), .i_srst(i_srst), .sel_n(ifc.sel_n),
        .row_strobe_n(ifc.row_strobe_n), .col_strobe_n(ifc.col_strobe_n),
        .wr_en_n(ifc.wr_en_n), .addr(ifc.addr), .byte_mask(ifc.byte_mask),
        .dq_oe_dev(ifc.dq_oe_dev));
    always #2 i_mclk = ~i_mclk;
    // ****
    // Tasks
    // ****
    task automatic chk(string nm, logic [24:0] e, logic [24:0] s);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    task automatic cmd(sbm_cmd_t c, logic [1:0] b, logic [11:0] a);
        int w;
        w = 0;
        @(negedge i_mclk);
        i_req = 1'b1;
        i_cmd = c;
        i_bank = b;
        i_addr = a;
        while (o_ready !== 1'b1 && w < 50) begin
            @(negedge i_mclk);
            w++;
        end
        if (w >= 50) begin
            num_errors++;
            $display("[ERR] ready exp 1 got %b", o_ready);
        end
        @(posedge i_mclk);
    endtask : cmd
    function automatic logic [8:0] ecol(logic [11:0] md, logic [8:0] c, int k);
        int l;
        l = (md[2:0] == 3'h7) ? 512 : (1 << md[2:0]);
        if (md[3] && l < 512) begin
            return 9'((c & ~(l - 1)) | ((c ^ k) & (l - 1)));
        end
        return 9'((c & ~(l - 1)) | ((c + k) & (l - 1)));
    endfunction : ecol
    task automatic run(int t, logic [11:0] md, logic [8:0] c, logic [1:0] mk);
        int l;
        int wl;
        logic [1:0] b;
        logic ac;
        bit gl;
        bit good;
        l = (md[2:0] == 3'h7) ? 512 : (1 << md[2:0]);
        wl = md[9] ? 1 : l;
        b = 2'($urandom);
        ac = 1'($urandom);
        gl = md[8:7] == 2'h0 && md[2:0] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
        good = gl && md[6:4] inside {3'h2, 3'h3};
        i_mask = mk;
        cmd(SBM_CMD_LOAD, 2'h0, md);
        if (!opened[b]) begin
            cmd(SBM_CMD_ACTIVE, b, 12'($urandom));
        end
        opened[b] = opened[b] | (md[8:7] == 2'h0);
        for (int k = 0; k < wl && gl; k++) begin
            col_q.push_back(ecol(md, c, k));
        end
        cmd(SBM_CMD_WRITE, b, {3'h0, c});
        cmd(SBM_CMD_NOP, b, 12'($urandom));
        repeat (l + 2) @(negedge i_mclk);
        for (int k = 0; k < l && good; k++) begin
            exp_q.push_back({{8{!mk[1]}}, {8{!mk[0]}}, ecol(md, c, k) & {!mk[1], {8{!mk[0]}}}});
            col_q.push_back(ecol(md, c, k));
        end
        cmd(SBM_CMD_READ, b, {1'b0, ac, 1'b0, c});
        cmd(SBM_CMD_NOP, b, 12'($urandom));
        cmd(SBM_CMD_INHIBIT, b, 12'($urandom));
        @(negedge i_mclk);
        i_req = 1'b0;
        repeat (l + 4) @(negedge i_mclk);
        if (ac && l < 512 && good) begin
            opened[b] = 1'b0;
        end
        chk("beats left", 25'h0, 25'(exp_q.size()));
        chk("cols left", 25'h0, 25'(col_q.size()));
        chk("mode", {md[9], md[8:7] == 2'h0, md}, {o_wr_single, o_normal, o_mode});
        chk("rows", 25'(opened), 25'(o_row_open));
        $display("test %0d done", t);
    endtask : run
    // Each driven beat is matched against the oldest expected beat
    always @(negedge i_mclk) begin
        if (!i_srst && |ifc.dq_oe_dev) begin
            chk("beat", exp_q.size() ? exp_q.pop_front() : 25'h0,
                {ifc.dq_oe_dev, ifc.dq_from_dev[8:0] & ifc.dq_oe_dev[8:0]});
        end
        if (!i_srst && o_col_valid) begin
            chk("col", col_q.size() ? 25'(col_q.pop_front()) : 25'h1ffffff, 25'(o_col));
        end
    end
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            $display("[ERR] timeout exp 0 got %0d", cyc);
            print_verdict();
        end
    end
    initial begin
        logic [11:0] md;
        opened = 4'h0;
        void'($urandom(32'h7e38));
        repeat (12) @(negedge i_mclk);
        i_srst = 1'b0;
        chk("reset", 25'h0, {9'h0, o_row_open, o_mode});
        for (int i = 0; i < 32; i++) begin
            md = {2'h0, 1'($urandom), 2'h0, i[3] ? 3'h3 : 3'h2, i[2], 1'b0, i[1:0]};
            run(i, md, 9'($urandom), i[4] ? 2'(1 + $urandom % 2) : 2'h0);
        end
        run(32, 12'h037, 9'h1fe, 2'h0);
        run(33, 12'h0a3, 9'h005, 2'h0);
        run(34, 12'h043, 9'h005, 2'h0);
        run(35, 12'h024, 9'h005, 2'h0);
        print_verdict();
    end
endmodule : sbm_tb_top
